// *** hdl/dcpmb_regs.svh ***
`ifndef DCPMB_REGS_SVH
`define DCPMB_REGS_SVH
// Summary of operation
// - Erase guard flag reads 0 while protection is active, 1 when erase is allowed.
// - Each unlock key register takes one write per reset; later writes are ignored.
// - Matching keys at 0x01C and 0x504 release protection and start full erase.
// - Debugger write of outgoing word at 0x020 sets word waiting in its status.
// - Debugger read of incoming word at 0x028 sets word taken in its status.
// - Debugger outgoing status at 0x024 shows whether the CPU has read the word.
// - CPU incoming word at 0x400 is a 32-bit read-only word, reset zero.
// - CPU outgoing status at 0x484 shows whether the debugger read word 0x480.
// - CPU lock register 0x500 bit 0 resets 0; a first write of 1 locks the erase, later writes are ignored.
// - Send marks both statuses waiting; receive clears receiver first, sender next.
// - Both sides must write their keys before erase runs and protection is released.

// Debugger-side offsets.
`define DCPMB_DBG_GUARD_STATE  8'h18
`define DCPMB_DBG_UNLOCK_KEY   8'h1C
`define DCPMB_DBG_OUT_WORD     8'h20
`define DCPMB_DBG_OUT_STATE    8'h24
`define DCPMB_DBG_IN_WORD      8'h28
`define DCPMB_DBG_IN_STATE     8'h2C
`define DCPMB_DBG_PORT_ID      8'hFC
// CPU-side offsets.
`define DCPMB_CPU_IN_WORD      12'h400
`define DCPMB_CPU_IN_STATE     12'h404
`define DCPMB_CPU_OUT_WORD     12'h480
`define DCPMB_CPU_OUT_STATE    12'h484
`define DCPMB_CPU_ERASE_LOCK   12'h500
`define DCPMB_CPU_UNLOCK_KEY   12'h504
// Field positions and values.
`define DCPMB_WAIT_BIT         0
`define DCPMB_LOCK_BIT         0
`define DCPMB_GUARD_BIT        0
`define DCPMB_ZERO_WORD        32'h0000_0000
// Identification value; arbitrary.
`define DCPMB_PORT_ID_VALUE    32'h0000_1234
// Buffer shape.
`define DCPMB_WORD_W           32
`define DCPMB_FIFO_DEPTH       16
`endif

// *** hdl/dcpmb_pkg.sv ***
`include "dcpmb_regs.svh"
package dcpmb_pkg;
  // Debugger access port request.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } dcpmb_dbg_req_t;
  // CPU peripheral request.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } dcpmb_cpu_req_t;
  // Read answer, one cycle after the read request.
  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } dcpmb_rsp_t;
endpackage : dcpmb_pkg

// *** hdl/dcpmb_mem.sv ***
`timescale 1ns/10ps
module dcpmb_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock.
  input  wire logic             sys_clk,
  // Write side.
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // Read side, data registered.
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] store [DEPTH];

  // Write-first storage so a word written to the read address appears at once.
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
    rdData <= (wrEn && (wrAddr == rdAddr)) ? wrData : store[rdAddr];
  end
endmodule : dcpmb_mem

// *** hdl/dcpmb_fifo.sv ***
`timescale 1ns/10ps
module dcpmb_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  // Filling side.
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Draining side.
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [AW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
  logic [AW:0]   count_reg, count_next;
  logic          full_reg, full_next, filled_reg, filled_next;
  logic          push, pop;

  assign inReady  = !full_reg;
  assign outValid = filled_reg;

  // Pointer and level update; flags are registered so inReady and outValid are clean.
  always_comb begin
    push        = inValid && !full_reg;
    pop         = outReady && filled_reg;
    wrPtr_next  = push ? AW'(wrPtr_reg + 1'b1) : wrPtr_reg;
    rdPtr_next  = pop ? AW'(rdPtr_reg + 1'b1) : rdPtr_reg;
    count_next  = (AW+1)'(count_reg + push - pop);
    full_next   = (count_next == (AW+1)'(DEPTH));
    filled_next = (count_next != '0);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_reg  <= '0;
      rdPtr_reg  <= '0;
      count_reg  <= '0;
      full_reg   <= 1'b0;
      filled_reg <= 1'b0;
    end else begin
      wrPtr_reg  <= wrPtr_next;
      rdPtr_reg  <= rdPtr_next;
      count_reg  <= count_next;
      full_reg   <= full_next;
      filled_reg <= filled_next;
    end
  end

  // Head word is read ahead at the next read pointer.
  dcpmb_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) store_u (
    .sys_clk (sys_clk),
    .wrEn    (push),
    .wrAddr  (wrPtr_reg),
    .wrData  (inData),
    .rdAddr  (rdPtr_next),
    .rdData  (outData)
  );
endmodule : dcpmb_fifo

// *** hdl/dcpmb_top.sv ***
`timescale 1ns/10ps
`include "dcpmb_regs.svh"
module dcpmb_top
  import dcpmb_pkg::*;
(
  // Clock and reset.
  input  wire logic           sys_clk,
  input  wire logic           arst_n,
  // Debugger access port.
  input  wire dcpmb_dbg_req_t dbgReq,
  output dcpmb_rsp_t          dbgRsp,
  output logic                dbgWriteReady,
  // CPU peripheral port.
  input  wire dcpmb_cpu_req_t cpuReq,
  output dcpmb_rsp_t          cpuRsp,
  // Erase guard.
  input  wire logic           eraseGuardStrap,
  output logic                fullDeviceErase,
  output logic                eraseGuardFlag
);
  // Address decode shared by both ports.
  function automatic logic hit12(input logic [11:0] addr, input logic [11:0] offs);
    hit12 = (addr == offs);
  endfunction : hit12

  logic        dbgWr, dbgRd, cpuWr, cpuRd;
  logic        fifoInValid, fifoInReady, fifoOutValid, fifoOutReady;
  logic [31:0] fifoOutData;
  logic        cpuTake, cpuLoad, cpuOutWr, dbgInRead, dbgOutWr;
  logic        dbgKeyWr, cpuKeyWr, lockWr, protectOn, unlockNow;

  // Mailbox state.
  logic [31:0] cpuInWord_reg, cpuInWord_next;
  logic        cpuInWait_reg, cpuInWait_next;
  logic        dbgOutWait_reg, dbgOutWait_next;
  logic [31:0] cpuOutWord_reg, cpuOutWord_next;
  logic        dbgInWait_reg, dbgInWait_next;
  logic        cpuOutWait_reg, cpuOutWait_next;
  // Erase guard state.
  logic        strapSeen_reg, strapSeen_next, strap_reg, strap_next;
  logic [31:0] dbgKey_reg, dbgKey_next, cpuKey_reg, cpuKey_next;
  logic        dbgKeyDone_reg, dbgKeyDone_next, cpuKeyDone_reg, cpuKeyDone_next;
  logic        lock_reg, lock_next, lockDone_reg, lockDone_next;
  logic        unlocked_reg, unlocked_next, eraseStart_reg, eraseStart_next;
  logic        guardFlag_reg, guardFlag_next;
  // Answers.
  dcpmb_rsp_t  dbgRsp_reg, dbgRsp_next, cpuRsp_reg, cpuRsp_next;

  assign dbgRsp          = dbgRsp_reg;
  assign cpuRsp          = cpuRsp_reg;
  assign dbgWriteReady   = fifoInReady;
  assign fullDeviceErase = eraseStart_reg;
  assign eraseGuardFlag  = guardFlag_reg;

  // Request strobes for each register action.
  always_comb begin
    dbgWr        = dbgReq.valid && dbgReq.write;
    dbgRd        = dbgReq.valid && !dbgReq.write;
    cpuWr        = cpuReq.valid && cpuReq.write;
    cpuRd        = cpuReq.valid && !cpuReq.write;
    dbgOutWr     = dbgWr && hit12({4'h0, dbgReq.addr}, {4'h0, `DCPMB_DBG_OUT_WORD});
    dbgInRead    = dbgRd && hit12({4'h0, dbgReq.addr}, {4'h0, `DCPMB_DBG_IN_WORD});
    dbgKeyWr     = dbgWr && hit12({4'h0, dbgReq.addr}, {4'h0, `DCPMB_DBG_UNLOCK_KEY});
    cpuTake      = cpuRd && hit12(cpuReq.addr, `DCPMB_CPU_IN_WORD);
    cpuOutWr     = cpuWr && hit12(cpuReq.addr, `DCPMB_CPU_OUT_WORD);
    cpuKeyWr     = cpuWr && hit12(cpuReq.addr, `DCPMB_CPU_UNLOCK_KEY);
    lockWr       = cpuWr && hit12(cpuReq.addr, `DCPMB_CPU_ERASE_LOCK);
    fifoInValid  = dbgOutWr;
    fifoOutReady = !cpuInWait_reg || cpuTake;
    cpuLoad      = fifoOutValid && fifoOutReady;
  end

  // Debugger words queue here; a full queue stalls the debugger through its ready.
  dcpmb_fifo #(.WIDTH(`DCPMB_WORD_W), .DEPTH(`DCPMB_FIFO_DEPTH)) outQueue_u (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (dbgReq.wdata),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // Mailbox flags; a new word wins over a take in the same cycle.
  always_comb begin
    cpuInWord_next  = cpuLoad ? fifoOutData : cpuInWord_reg;
    cpuInWait_next  = cpuLoad || (cpuInWait_reg && !cpuTake);
    dbgOutWait_next = (dbgOutWr && fifoInReady) || fifoOutValid || cpuInWait_reg;
    cpuOutWord_next = cpuOutWr ? cpuReq.wdata : cpuOutWord_reg;
    dbgInWait_next  = cpuOutWr || (dbgInWait_reg && !dbgInRead);
    cpuOutWait_next = cpuOutWr || dbgInWait_reg;
  end

  // Erase guard: write-once keys, write-once lock, release on matching keys.
  always_comb begin
    strapSeen_next  = 1'b1;
    strap_next      = strapSeen_reg ? strap_reg : eraseGuardStrap;
    dbgKeyDone_next = dbgKeyDone_reg || dbgKeyWr;
    dbgKey_next     = (dbgKeyWr && !dbgKeyDone_reg) ? dbgReq.wdata : dbgKey_reg;
    cpuKeyDone_next = cpuKeyDone_reg || cpuKeyWr;
    cpuKey_next     = (cpuKeyWr && !cpuKeyDone_reg) ? cpuReq.wdata : cpuKey_reg;
    lockDone_next   = lockDone_reg || lockWr;
    lock_next       = (lockWr && !lockDone_reg) ? cpuReq.wdata[`DCPMB_LOCK_BIT] : lock_reg;
    unlockNow       = dbgKeyDone_reg && cpuKeyDone_reg && (dbgKey_reg == cpuKey_reg)
                      && !unlocked_reg;
    unlocked_next   = unlocked_reg || unlockNow;
    eraseStart_next = unlockNow;
    protectOn       = (strap_reg || lock_reg) && !unlocked_reg;
    guardFlag_next  = !((strap_next || lock_next) && !unlocked_next);
  end

  // Read answers; unmapped or write-only offsets read as zero.
  always_comb begin
    dbgRsp_next.valid = dbgRd;
    dbgRsp_next.data  = `DCPMB_ZERO_WORD;
    unique case (dbgReq.addr)
      `DCPMB_DBG_GUARD_STATE: dbgRsp_next.data[`DCPMB_GUARD_BIT] = guardFlag_reg;
      `DCPMB_DBG_OUT_STATE:   dbgRsp_next.data[`DCPMB_WAIT_BIT]  = dbgOutWait_reg;
      `DCPMB_DBG_IN_WORD:     dbgRsp_next.data = cpuOutWord_reg;
      `DCPMB_DBG_IN_STATE:    dbgRsp_next.data[`DCPMB_WAIT_BIT]  = dbgInWait_reg;
      `DCPMB_DBG_PORT_ID:     dbgRsp_next.data = `DCPMB_PORT_ID_VALUE;
      default:                dbgRsp_next.data = `DCPMB_ZERO_WORD;
    endcase
    if (!dbgRd) begin
      dbgRsp_next.data = `DCPMB_ZERO_WORD;
    end
    cpuRsp_next.valid = cpuRd;
    cpuRsp_next.data  = `DCPMB_ZERO_WORD;
    unique case (cpuReq.addr)
      `DCPMB_CPU_IN_WORD:    cpuRsp_next.data = cpuInWord_reg;
      `DCPMB_CPU_IN_STATE:   cpuRsp_next.data[`DCPMB_WAIT_BIT] = cpuInWait_reg;
      `DCPMB_CPU_OUT_STATE:  cpuRsp_next.data[`DCPMB_WAIT_BIT] = cpuOutWait_reg;
      `DCPMB_CPU_ERASE_LOCK: cpuRsp_next.data[`DCPMB_LOCK_BIT] = lock_reg;
      default:               cpuRsp_next.data = `DCPMB_ZERO_WORD;
    endcase
    if (!cpuRd) begin
      cpuRsp_next.data = `DCPMB_ZERO_WORD;
    end
  end

  // State registers; reset leaves mailboxes empty and the guard flag at 0; the strap is sampled on the first edge after reset.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpuInWord_reg  <= `DCPMB_ZERO_WORD;
      cpuInWait_reg  <= 1'b0;
      dbgOutWait_reg <= 1'b0;
      cpuOutWord_reg <= `DCPMB_ZERO_WORD;
      dbgInWait_reg  <= 1'b0;
      cpuOutWait_reg <= 1'b0;
      strapSeen_reg  <= 1'b0;
      strap_reg      <= 1'b0;
      dbgKey_reg     <= `DCPMB_ZERO_WORD;
      cpuKey_reg     <= `DCPMB_ZERO_WORD;
      dbgKeyDone_reg <= 1'b0;
      cpuKeyDone_reg <= 1'b0;
      lock_reg       <= 1'b0;
      lockDone_reg   <= 1'b0;
      unlocked_reg   <= 1'b0;
      eraseStart_reg <= 1'b0;
      guardFlag_reg  <= 1'b0;
      dbgRsp_reg     <= '0;
      cpuRsp_reg     <= '0;
    end else begin
      cpuInWord_reg  <= cpuInWord_next;
      cpuInWait_reg  <= cpuInWait_next;
      dbgOutWait_reg <= dbgOutWait_next;
      cpuOutWord_reg <= cpuOutWord_next;
      dbgInWait_reg  <= dbgInWait_next;
      cpuOutWait_reg <= cpuOutWait_next;
      strapSeen_reg  <= strapSeen_next;
      strap_reg      <= strap_next;
      dbgKey_reg     <= dbgKey_next;
      cpuKey_reg     <= cpuKey_next;
      dbgKeyDone_reg <= dbgKeyDone_next;
      cpuKeyDone_reg <= cpuKeyDone_next;
      lock_reg       <= lock_next;
      lockDone_reg   <= lockDone_next;
      unlocked_reg   <= unlocked_next;
      eraseStart_reg <= eraseStart_next;
      guardFlag_reg  <= guardFlag_next;
      dbgRsp_reg     <= dbgRsp_next;
      cpuRsp_reg     <= cpuRsp_next;
    end
  end

  // Checks on the mailbox and erase guard behaviour.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  guard_flag_a: assert property (strapSeen_reg && protectOn |-> !guardFlag_reg)
    else $error("guard flag shows erase allowed while protected");
  dbg_key_once_a: assert property (dbgKeyDone_reg |=> $stable(dbgKey_reg))
    else $error("debugger key changed after first write");
  cpu_key_once_a: assert property (cpuKeyDone_reg |=> $stable(cpuKey_reg))
    else $error("cpu key changed after first write");
  erase_match_a: assert property (unlockNow |=> eraseStart_reg && unlocked_reg ##1 !eraseStart_reg)
    else $error("matching keys did not give one erase pulse");
  out_wait_a: assert property (dbgOutWr && fifoInReady |=> dbgOutWait_reg ##1 (cpuInWait_reg || fifoOutValid))
    else $error("debugger word not marked waiting");
  in_taken_a: assert property (dbgInRead && !cpuOutWr |=> !dbgInWait_reg)
    else $error("debugger read did not mark word taken");
  out_state_a: assert property (cpuInWait_reg |=> dbgOutWait_reg)
    else $error("debugger status cleared before cpu took word");
  cpu_take_a: assert property (cpuTake && !fifoOutValid |=> !cpuInWait_reg && $stable(cpuInWord_reg))
    else $error("cpu read did not empty incoming slot");
  cpu_send_a: assert property (cpuOutWr |=> cpuOutWait_reg && dbgInWait_reg)
    else $error("cpu write not marked waiting on both sides");
  lock_once_a: assert property (lockDone_reg |=> $stable(lock_reg))
    else $error("erase lock changed after first write");
  sender_lag_a: assert property ($fell(dbgInWait_reg) && !cpuOutWr |-> cpuOutWait_reg ##1 !cpuOutWait_reg)
    else $error("sender status did not clear one cycle after receiver");
  both_keys_a: assert property ($rose(unlocked_reg) |-> $past(dbgKeyDone_reg) && $past(cpuKeyDone_reg))
    else $error("unlock without both keys");
  // The flag must also open once nothing protects the device any more.
  guard_open_a: assert property (strapSeen_reg && !protectOn |-> guardFlag_reg)
    else $error("guard flag shows protected while erase allowed");
  // A word moved into the incoming slot is waiting on both sides.
  cpu_load_a: assert property (cpuLoad |=> cpuInWait_reg && dbgOutWait_reg)
    else $error("loaded word not marked waiting on both sides");
  // The first lock write takes bit zero of the written word.
  lock_set_a: assert property (lockWr && !lockDone_reg |=> lock_reg == $past(cpuReq.wdata[`DCPMB_LOCK_BIT]))
    else $error("first lock write not taken");
  // Leaving reset, both mailboxes are empty and their words read zero.
  reset_empty_a: assert property ($rose(arst_n) |-> !cpuInWait_reg && !dbgOutWait_reg && !dbgInWait_reg
      && !cpuOutWait_reg && (cpuInWord_reg == `DCPMB_ZERO_WORD) && (cpuOutWord_reg == `DCPMB_ZERO_WORD))
    else $error("mailbox not empty after reset");
endmodule : dcpmb_top

// *** verification/dcpmb_dbg_model.sv ***
`timescale 1ns/10ps
`include "dcpmb_regs.svh"
module dcpmb_dbg_model
  import dcpmb_pkg::*;
(
  // Clock.
  input  wire logic       sys_clk,
  // Access port towards the block.
  output dcpmb_dbg_req_t  dbgReq,
  input  wire dcpmb_rsp_t dbgRsp,
  input  wire logic       dbgWriteReady
);
  // Writes that never found room; the bench adds these to its mismatches.
  int stallErr = 0;

  // The port starts idle.
  initial begin
    dbgReq = '0;
  end

  // One access, driven after a falling edge and held up to the rising edge that takes it.
  task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        input bit holdReady, output logic [31:0] rdata);
    int waitCnt;
    waitCnt = 0;
    rdata = 'x;
    @(negedge sys_clk);
    dbgReq = '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
    // A queued write waits for room; without the wait it may be dropped on purpose.
    while (holdReady && dbgWriteReady !== 1'b1 && waitCnt < 50) begin
      waitCnt++;
      @(negedge sys_clk);
    end
    if (holdReady && dbgWriteReady !== 1'b1) begin
      stallErr++;
      $display("[ERR] write ready expected 1 seen %b", dbgWriteReady);
    end
    @(negedge sys_clk);
    // The answer stands only in the cycle after the taking edge, so it is read here.
    if (!wr) begin
      rdata = (dbgRsp.valid === 1'b1) ? dbgRsp.data : 'x;
    end
    // A released port shows the inverse of the last value, never a stale copy.
    dbgReq = '{valid: 1'b0, write: ~wr, addr: ~addr, wdata: ~wdata};
  endtask : access

  // The debugger half of the unlock goes to its own key register.
  task automatic send_key(input logic [31:0] key);
    logic [31:0] unused;
    access(1'b1, `DCPMB_DBG_UNLOCK_KEY, key, 1'b0, unused);
  endtask : send_key
endmodule : dcpmb_dbg_model

// *** verification/dcpmb_top_test.sv ***
`timescale 1ns/10ps
`include "dcpmb_regs.svh"
module dcpmb_top_test
  import dcpmb_pkg::*;
;
  logic           sys_clk;
  logic           arst_n;
  dcpmb_dbg_req_t dbgReq;
  dcpmb_rsp_t     dbgRsp;
  logic           dbgWriteReady;
  dcpmb_cpu_req_t cpuReq;
  dcpmb_rsp_t     cpuRsp;
  logic           eraseGuardStrap;
  logic           fullDeviceErase;
  logic           eraseGuardFlag;
  logic [31:0]    rd;
  int             error_cnt;
  int             checked;
  int             eraseCnt;
  int             n;

  dcpmb_top dcpmb_top_i (.sys_clk(sys_clk), .arst_n(arst_n), .dbgReq(dbgReq), .dbgRsp(dbgRsp),
    .dbgWriteReady(dbgWriteReady), .cpuReq(cpuReq), .cpuRsp(cpuRsp), .eraseGuardStrap(eraseGuardStrap),
    .fullDeviceErase(fullDeviceErase), .eraseGuardFlag(eraseGuardFlag));
  dcpmb_dbg_model dcpmb_dbg_model_i (.sys_clk(sys_clk), .dbgReq(dbgReq), .dbgRsp(dbgRsp),
    .dbgWriteReady(dbgWriteReady));

  // Clock at 10 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Counts cycles with the erase start pulse high.
  always @(posedge sys_clk) begin
    if (fullDeviceErase === 1'b1) eraseCnt++;
  end

  // Word comparison.
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  // Flag comparison.
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  // One CPU access; a released port shows inverted values.
  task automatic cpu_access(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    @(negedge sys_clk);
    cpuReq = '{valid: 1'b1, write: wr, addr: addr, wdata: wdata};
    @(negedge sys_clk);
    // The answer stands only in the cycle after the taking edge.
    rd = 'x;
    if (!wr) begin
      rd = (cpuRsp.valid === 1'b1) ? cpuRsp.data : 'x;
    end
    cpuReq = '{valid: 1'b0, write: ~wr, addr: ~addr, wdata: ~wdata};
  endtask : cpu_access

  // Reads a CPU register and compares it.
  task automatic cpu_rd(input string what, input logic [11:0] addr, input logic [31:0] exp);
    cpu_access(1'b0, addr, 32'h0000_0000);
    chk_word(what, exp, rd);
  endtask : cpu_rd

  // Reads a debugger register and compares it.
  task automatic dbg_rd(input string what, input logic [7:0] addr, input logic [31:0] exp);
    dcpmb_dbg_model_i.access(1'b0, addr, 32'h0000_0000, 1'b0, rd);
    chk_word(what, exp, rd);
  endtask : dbg_rd

  // Reset for five cycles with the given protection strap.
  task automatic do_reset(input logic strap);
    @(negedge sys_clk);
    arst_n = 1'b0;
    eraseGuardStrap = strap;
    repeat (5) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    eraseCnt = 0;
  endtask : do_reset

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    error_cnt += dcpmb_dbg_model_i.stallErr;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // Watchdog at 20000 cycles, well beyond the few hundred cycles the tests need.
  initial begin
    #(20000 * 100);
    error_cnt++;
    $display("[ERR] watchdog expected finish seen timeout");
    test_done();
  end

  // Test sequence.
  initial begin
    error_cnt = 0;
    checked = 0;
    eraseCnt = 0;
    arst_n = 1'b0;
    eraseGuardStrap = 1'b1;
    cpuReq = '0;
    do_reset(1'b1);
    cpu_rd("cpu in word", `DCPMB_CPU_IN_WORD, `DCPMB_ZERO_WORD);
    cpu_rd("cpu in state", `DCPMB_CPU_IN_STATE, 32'h0000_0000);
    cpu_rd("cpu out state", `DCPMB_CPU_OUT_STATE, 32'h0000_0000);
    cpu_rd("erase lock", `DCPMB_CPU_ERASE_LOCK, 32'h0000_0000);
    dbg_rd("dbg out state", `DCPMB_DBG_OUT_STATE, 32'h0000_0000);
    dbg_rd("dbg in state", `DCPMB_DBG_IN_STATE, 32'h0000_0000);
    dbg_rd("dbg in word", `DCPMB_DBG_IN_WORD, 32'h0000_0000);
    dbg_rd("guard state", `DCPMB_DBG_GUARD_STATE, 32'h0000_0000);
    dbg_rd("port id", `DCPMB_DBG_PORT_ID, `DCPMB_PORT_ID_VALUE);
    dbg_rd("unmapped", 8'h40, 32'h0000_0000);
    chk_bit("guard flag", 1'b0, eraseGuardFlag);
    $display("test reset_values done");
    dcpmb_dbg_model_i.access(1'b1, `DCPMB_DBG_OUT_WORD, 32'hA5A5_0001, 1'b1, rd);
    dbg_rd("dbg out waiting", `DCPMB_DBG_OUT_STATE, 32'h0000_0001);
    cpu_rd("cpu in waiting", `DCPMB_CPU_IN_STATE, 32'h0000_0001);
    cpu_rd("cpu in word", `DCPMB_CPU_IN_WORD, 32'hA5A5_0001);
    cpu_rd("cpu in taken", `DCPMB_CPU_IN_STATE, 32'h0000_0000);
    dbg_rd("dbg out taken", `DCPMB_DBG_OUT_STATE, 32'h0000_0000);
    $display("test dbg_to_cpu done");
    cpu_access(1'b1, `DCPMB_CPU_OUT_WORD, 32'h5A5A_0002);
    cpu_rd("cpu out waiting", `DCPMB_CPU_OUT_STATE, 32'h0000_0001);
    dbg_rd("dbg in waiting", `DCPMB_DBG_IN_STATE, 32'h0000_0001);
    dbg_rd("dbg in word", `DCPMB_DBG_IN_WORD, 32'h5A5A_0002);
    dbg_rd("dbg in taken", `DCPMB_DBG_IN_STATE, 32'h0000_0000);
    cpu_rd("cpu out taken", `DCPMB_CPU_OUT_STATE, 32'h0000_0000);
    $display("test cpu_to_dbg done");
    // Fill the queue while the CPU stalls, offer one refused word, then drain.
    n = 0;
    while (dbgWriteReady === 1'b1 && n < 20) begin
      dcpmb_dbg_model_i.access(1'b1, `DCPMB_DBG_OUT_WORD, 32'hF000_0000 + 32'(n), 1'b1, rd);
      n++;
      @(negedge sys_clk);
    end
    // The queue holds its full depth and the incoming slot one word more.
    chk_word("queue depth", 32'(`DCPMB_FIFO_DEPTH + 1), 32'(n));
    chk_bit("write ready full", 1'b0, dbgWriteReady);
    dcpmb_dbg_model_i.access(1'b1, `DCPMB_DBG_OUT_WORD, 32'hDEAD_0000, 1'b0, rd);
    for (int i = 0; i < n; i++) begin
      repeat (2) @(negedge sys_clk);
      cpu_rd("cpu in queued", `DCPMB_CPU_IN_STATE, 32'h0000_0001);
      cpu_rd("cpu drain word", `DCPMB_CPU_IN_WORD, 32'hF000_0000 + 32'(i));
    end
    repeat (3) @(negedge sys_clk);
    cpu_rd("cpu in empty", `DCPMB_CPU_IN_STATE, 32'h0000_0000);
    dbg_rd("dbg out empty", `DCPMB_DBG_OUT_STATE, 32'h0000_0000);
    chk_bit("write ready empty", 1'b1, dbgWriteReady);
    $display("test queue done");
    do_reset(1'b0);
    dbg_rd("guard open", `DCPMB_DBG_GUARD_STATE, 32'h0000_0001);
    cpu_access(1'b1, `DCPMB_CPU_ERASE_LOCK, 32'h0000_0001);
    cpu_rd("lock set", `DCPMB_CPU_ERASE_LOCK, 32'h0000_0001);
    cpu_access(1'b1, `DCPMB_CPU_ERASE_LOCK, 32'h0000_0000);
    cpu_rd("lock kept", `DCPMB_CPU_ERASE_LOCK, 32'h0000_0001);
    dbg_rd("guard locked", `DCPMB_DBG_GUARD_STATE, 32'h0000_0000);
    $display("test lock done");
    do_reset(1'b1);
    dcpmb_dbg_model_i.send_key(32'h0000_00A1);
    dcpmb_dbg_model_i.send_key(32'h0000_00B2);
    cpu_access(1'b1, `DCPMB_CPU_UNLOCK_KEY, 32'h0000_00B2);
    repeat (5) @(negedge sys_clk);
    chk_word("erase pulses", 32'h0000_0000, 32'(eraseCnt));
    chk_bit("guard flag", 1'b0, eraseGuardFlag);
    do_reset(1'b1);
    cpu_access(1'b1, `DCPMB_CPU_UNLOCK_KEY, 32'h0000_00C3);
    cpu_access(1'b1, `DCPMB_CPU_UNLOCK_KEY, 32'h0000_00D4);
    repeat (5) @(negedge sys_clk);
    chk_word("erase pulses one key", 32'h0000_0000, 32'(eraseCnt));
    dcpmb_dbg_model_i.send_key(32'h0000_00C3);
    repeat (5) @(negedge sys_clk);
    chk_word("erase pulses", 32'h0000_0001, 32'(eraseCnt));
    chk_bit("guard flag", 1'b1, eraseGuardFlag);
    dbg_rd("guard open", `DCPMB_DBG_GUARD_STATE, 32'h0000_0001);
    $display("test unlock done");
    test_done();
  end
endmodule : dcpmb_top_test
